// [tic_pkg.sv]
// shared constants and types of the control input conditioner
package tic_pkg;
	// clock and sampling
	localparam int TIC_CLK_HZ = 25_000_000;
	localparam int TIC_SAMPLE_MS = 50;
	localparam int TIC_STABLE_MS = 100;
	localparam int TIC_EDGE_MS = 200;
	localparam int TIC_MAX_TOGGLE_HZ = 10;
	localparam int TIC_TICK_CYCLES = TIC_CLK_HZ / 1000 * TIC_SAMPLE_MS;
	localparam int TIC_SAMPLES_STABLE = TIC_STABLE_MS / TIC_SAMPLE_MS;

	// register byte offsets
	localparam logic [3:0] TIC_CTRL_OFS = 4'h0;
	localparam logic [3:0] TIC_STATUS_OFS = 4'h4;
	localparam logic [3:0] TIC_EDGES_OFS = 4'h8;

	// control register fields
	localparam int TIC_MODE_LSB = 0;
	localparam int TIC_MODE_W = 4;
	localparam int TIC_DIRPOL_BIT = 4;
	localparam int TIC_ALARM_BIT = 8;
	localparam int TIC_EDIT_BIT = 9;

	// status register fields
	localparam int TIC_ST_TRIG_BIT = 0;
	localparam int TIC_ST_DIR_BIT = 1;
	localparam int TIC_ST_EVT_BIT = 2;
	localparam int TIC_ST_INFUSE_BIT = 3;
	localparam int TIC_ST_KNOWN_BIT = 4;

	// reset values
	localparam logic [3:0] TIC_MODE_RST = 4'hC;
	localparam logic TIC_DIRPOL_RST = 1'b0;
	localparam logic TIC_INFUSE_RST = 1'b1;

	// trigger mode encodings
	localparam logic [3:0] TIC_FOOT_TOGGLE_FALLING = 4'h0;
	localparam logic [3:0] TIC_FOOT_HOLD_MODE = 4'h1;
	localparam logic [3:0] TIC_FOOT_TOGGLE_RISING = 4'h2;
	localparam logic [3:0] TIC_GATE_HIGH_RUNS = 4'h3;
	localparam logic [3:0] TIC_BEGIN_ONLY_FALLING = 4'h4;
	localparam logic [3:0] TIC_BEGIN_ONLY_RISING = 4'h5;
	localparam logic [3:0] TIC_HALT_ONLY_FALLING = 4'h6;
	localparam logic [3:0] TIC_HALT_ONLY_RISING = 4'h7;
	localparam logic [3:0] TIC_RUN_ON_LOW_INPUT = 4'h8;
	localparam logic [3:0] TIC_RUN_ON_HIGH_INPUT = 4'h9;
	localparam logic [3:0] TIC_HALT_ON_LOW_INPUT = 4'hA;
	localparam logic [3:0] TIC_HALT_ON_HIGH_INPUT = 4'hB;
	localparam logic [3:0] TIC_TRIGGER_DISABLED = 4'hC;

	// direction setting
	localparam logic TIC_DIRECTION_FALLING_INFUSES = 1'b0;
	localparam logic TIC_DIRECTION_FALLING_WITHDRAWS = 1'b1;

	// filtered view of one input
	typedef struct packed {
		logic known;
		logic level;
		logic rise;
		logic fall;
	} tic_filt_type;
endpackage

// [tic_filter.sv]
// synchroniser, sampling filter and edge detector for one control input
`timescale 1ns/10ps
module tic_filter (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// sampling enable
	input wire logic tick_i,
	// raw pin
	input wire logic pin_i,
	// filtered result
	output tic_pkg::tic_filt_type filt_o
);
	logic sync1;
	logic sync2;
	logic prev;
	logic have_prev;
	tic_pkg::tic_filt_type filt;
	logic next_prev;
	logic next_have_prev;
	tic_pkg::tic_filt_type next_filt;

	always_comb begin
		next_prev = prev;
		next_have_prev = have_prev;
		next_filt = filt;
		next_filt.rise = 1'b0;
		next_filt.fall = 1'b0;
		if (tick_i) begin
			next_prev = sync2;
			next_have_prev = 1'b1;
			// two agreeing samples make a level
			if (have_prev && sync2 == prev) begin
				next_filt.known = 1'b1;
				next_filt.level = sync2;
				// first level after reset has nothing to compare with
				if (filt.known && sync2 != filt.level) begin
					next_filt.rise = sync2;
					next_filt.fall = ~sync2;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			prev <= 1'b1;
			have_prev <= 1'b0;
			filt <= '{known: 1'b0, level: 1'b1, rise: 1'b0, fall: 1'b0};
		end else begin
			sync1 <= pin_i;
			sync2 <= sync1;
			prev <= next_prev;
			have_prev <= next_have_prev;
			filt <= next_filt;
		end
	end

	assign filt_o = filt;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	level_needs_tick_a: assert property ($changed(filt.level) |-> $past(tick_i))
		else $error("filtered level moved without a sample tick");
	level_needs_agree_a: assert property ($changed(filt.level) |-> $past(sync2) == $past(prev))
		else $error("filtered level moved on disagreeing samples");
	edge_is_change_a: assert property (filt.rise || filt.fall |-> $changed(filt.level)
		&& $past(filt.known))
		else $error("edge reported without a recognised level change");
	edge_polarity_a: assert property (filt.fall |-> !filt.level && !filt.rise)
		else $error("falling edge not ending low");
endmodule

// [tic_conditioner.sv]
// control input conditioner: filters, trigger decode and register slave
`timescale 1ns/10ps
module tic_conditioner #(
	parameter int TICK_CYCLES = tic_pkg::TIC_TICK_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// control pins
	input wire logic trig_pin_i,
	input wire logic dir_pin_i,
	input wire logic event_pin_i,
	// avalon-mm slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// requests to the pumping program
	output logic key_toggle_o,
	output logic begin_req_o,
	output logic halt_req_o,
	output logic infuse_o,
	output logic event_level_o
);
	logic rst_s1;
	logic rst_n;
	logic [31:0] tick_cnt;
	logic tick;
	tic_pkg::tic_filt_type trig_f;
	tic_pkg::tic_filt_type dir_f;
	tic_pkg::tic_filt_type evt_f;

	// reset release through two flops
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// sample tick divider
	logic [31:0] next_tick_cnt;
	logic next_tick;
	always_comb begin
		next_tick = 1'b0;
		next_tick_cnt = tick_cnt + 32'h1;
		if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
			next_tick_cnt = 32'h0;
			next_tick = 1'b1;
		end
	end
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt <= 32'h0;
			tick <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			tick <= next_tick;
		end
	end

	tic_filter u_trig (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.tick_i(tick),
		.pin_i(trig_pin_i),
		.filt_o(trig_f)
	);
	tic_filter u_dir (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.tick_i(tick),
		.pin_i(dir_pin_i),
		.filt_o(dir_f)
	);
	// same filter as the other inputs
	tic_filter u_evt (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.tick_i(tick),
		.pin_i(event_pin_i),
		.filt_o(evt_f)
	);

	// register slave
	logic [3:0] trigger_mode_setting;
	logic dir_pol;
	logic alarm_active;
	logic keypad_editing;
	logic [15:0] trig_edges;
	logic [15:0] dir_edges;
	logic [3:0] next_mode;
	logic next_dir_pol;
	logic next_alarm;
	logic next_edit;
	logic [31:0] next_rdata;
	logic next_wait;
	logic req;
	logic done;

	assign req = avs_read_i || avs_write_i;
	assign done = req && !avs_waitrequest_o;

	always_comb begin
		next_mode = trigger_mode_setting;
		next_dir_pol = dir_pol;
		next_alarm = alarm_active;
		next_edit = keypad_editing;
		next_rdata = avs_readdata_o;
		// one wait cycle per access, then the answer
		next_wait = !(req && avs_waitrequest_o);
		if (done && avs_write_i && avs_address_i == tic_pkg::TIC_CTRL_OFS) begin
			next_mode = avs_writedata_i[tic_pkg::TIC_MODE_LSB +: tic_pkg::TIC_MODE_W];
			next_dir_pol = avs_writedata_i[tic_pkg::TIC_DIRPOL_BIT];
			next_alarm = avs_writedata_i[tic_pkg::TIC_ALARM_BIT];
			next_edit = avs_writedata_i[tic_pkg::TIC_EDIT_BIT];
		end
		if (req && avs_waitrequest_o && avs_read_i) begin
			next_rdata = 32'h0;
			unique case (avs_address_i)
				tic_pkg::TIC_CTRL_OFS: begin
					next_rdata[tic_pkg::TIC_MODE_LSB +: tic_pkg::TIC_MODE_W] = trigger_mode_setting;
					next_rdata[tic_pkg::TIC_DIRPOL_BIT] = dir_pol;
					next_rdata[tic_pkg::TIC_ALARM_BIT] = alarm_active;
					next_rdata[tic_pkg::TIC_EDIT_BIT] = keypad_editing;
				end
				tic_pkg::TIC_STATUS_OFS: begin
					next_rdata[tic_pkg::TIC_ST_TRIG_BIT] = trig_f.level;
					next_rdata[tic_pkg::TIC_ST_DIR_BIT] = dir_f.level;
					next_rdata[tic_pkg::TIC_ST_EVT_BIT] = evt_f.level;
					next_rdata[tic_pkg::TIC_ST_INFUSE_BIT] = infuse_o;
					next_rdata[tic_pkg::TIC_ST_KNOWN_BIT] = trig_f.known && dir_f.known
						&& evt_f.known;
				end
				tic_pkg::TIC_EDGES_OFS: next_rdata = {dir_edges, trig_edges};
				default: next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			trigger_mode_setting <= tic_pkg::TIC_MODE_RST;
			dir_pol <= tic_pkg::TIC_DIRPOL_RST;
			alarm_active <= 1'b0;
			keypad_editing <= 1'b0;
			avs_readdata_o <= 32'h0;
			avs_waitrequest_o <= 1'b1;
		end else begin
			trigger_mode_setting <= next_mode;
			dir_pol <= next_dir_pol;
			alarm_active <= next_alarm;
			keypad_editing <= next_edit;
			avs_readdata_o <= next_rdata;
			avs_waitrequest_o <= next_wait;
		end
	end

	// trigger and direction decode
	logic ignore;
	logic next_key;
	logic next_begin;
	logic next_halt;
	logic next_infuse;
	logic next_evt;
	logic [15:0] next_trig_edges;
	logic [15:0] next_dir_edges;

	assign ignore = alarm_active || keypad_editing;

	always_comb begin
		next_key = 1'b0;
		next_begin = 1'b0;
		next_halt = 1'b0;
		next_infuse = infuse_o;
		next_evt = evt_f.level;
		next_trig_edges = trig_edges + {15'h0, trig_f.rise || trig_f.fall};
		next_dir_edges = dir_edges + {15'h0, dir_f.rise || dir_f.fall};
		if (!ignore) begin
			// key emulation per mode
			unique case (trigger_mode_setting)
				tic_pkg::TIC_FOOT_TOGGLE_FALLING: next_key = trig_f.fall;
				tic_pkg::TIC_FOOT_TOGGLE_RISING: next_key = trig_f.rise;
				tic_pkg::TIC_FOOT_HOLD_MODE: begin
					next_begin = trig_f.fall;
					next_halt = trig_f.rise;
				end
				tic_pkg::TIC_GATE_HIGH_RUNS: begin
					next_begin = trig_f.rise;
					next_halt = trig_f.fall;
				end
				tic_pkg::TIC_BEGIN_ONLY_FALLING: next_begin = trig_f.fall;
				tic_pkg::TIC_BEGIN_ONLY_RISING: next_begin = trig_f.rise;
				tic_pkg::TIC_HALT_ONLY_FALLING: next_halt = trig_f.fall;
				tic_pkg::TIC_HALT_ONLY_RISING: next_halt = trig_f.rise;
				// level modes repeat each tick while the level holds
				tic_pkg::TIC_RUN_ON_LOW_INPUT: next_begin = tick && trig_f.known && !trig_f.level;
				tic_pkg::TIC_RUN_ON_HIGH_INPUT: next_begin = tick && trig_f.known && trig_f.level;
				tic_pkg::TIC_HALT_ON_LOW_INPUT: next_halt = tick && trig_f.known && !trig_f.level;
				tic_pkg::TIC_HALT_ON_HIGH_INPUT: next_halt = tick && trig_f.known && trig_f.level;
				default: next_key = 1'b0;
			endcase
			// direction mapping
			if (dir_f.fall) begin
				next_infuse = (dir_pol == tic_pkg::TIC_DIRECTION_FALLING_INFUSES);
			end else if (dir_f.rise) begin
				next_infuse = (dir_pol == tic_pkg::TIC_DIRECTION_FALLING_WITHDRAWS);
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			key_toggle_o <= 1'b0;
			begin_req_o <= 1'b0;
			halt_req_o <= 1'b0;
			infuse_o <= tic_pkg::TIC_INFUSE_RST;
			event_level_o <= 1'b1;
			trig_edges <= 16'h0;
			dir_edges <= 16'h0;
		end else begin
			key_toggle_o <= next_key;
			begin_req_o <= next_begin;
			halt_req_o <= next_halt;
			infuse_o <= next_infuse;
			event_level_o <= next_evt;
			trig_edges <= next_trig_edges;
			dir_edges <= next_dir_edges;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n);

	sequence s_ctrl_write;
		avs_write_i && !avs_waitrequest_o && avs_address_i == tic_pkg::TIC_CTRL_OFS;
	endsequence
	sequence s_foot_fall;
		trigger_mode_setting == tic_pkg::TIC_FOOT_TOGGLE_FALLING && trig_f.fall && !ignore;
	endsequence

	bus_wait_once_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("access not answered after one wait cycle");
	ctrl_write_a: assert property (s_ctrl_write |=> trigger_mode_setting
		== $past(avs_writedata_i[3:0]))
		else $error("trigger mode not updated by write");
	foot_toggle_a: assert property (s_foot_fall |=> key_toggle_o ##1 !key_toggle_o)
		else $error("foot toggle missed or pulse too long");
	ignore_inputs_a: assert property (ignore |=> !key_toggle_o && !begin_req_o && !halt_req_o
		&& $stable(infuse_o))
		else $error("request issued while inputs are ignored");
	disabled_mode_a: assert property (trigger_mode_setting == tic_pkg::TIC_TRIGGER_DISABLED
		|=> !key_toggle_o && !begin_req_o && !halt_req_o)
		else $error("disabled trigger issued a request");
	dir_infuse_a: assert property (dir_f.fall && !ignore && dir_pol
		== tic_pkg::TIC_DIRECTION_FALLING_INFUSES |=> infuse_o)
		else $error("falling direction did not select infuse");
	dir_withdraw_a: assert property (dir_f.fall && !ignore && dir_pol
		== tic_pkg::TIC_DIRECTION_FALLING_WITHDRAWS |=> !infuse_o)
		else $error("inverted direction did not select withdraw");
	hold_mode_a: assert property (trigger_mode_setting == tic_pkg::TIC_FOOT_HOLD_MODE && !ignore
		&& trig_f.rise |=> halt_req_o && !begin_req_o)
		else $error("hold mode rising edge did not stop");
	event_level_a: assert property (##1 event_level_o == $past(evt_f.level))
		else $error("event level not forwarded");
endmodule

// [tic_switch_model.sv]
// behavioural foot switch or controller driving the three control pins
`timescale 1ns/10ps
module tic_switch_model #(
	parameter int GAP = 80
) (
	// clock
	input wire logic clk_i,
	// wanted levels: [0] trigger, [1] direction, [2] event
	input wire logic [2:0] want_i,
	input wire logic glitch_i,
	// pins and status
	output logic [2:0] pin_o,
	output logic busy_o
);
	logic [2:0] held = 3'h7;
	int hold_cnt = 0;
	// one pin moves at a time, then every pin stays put for GAP cycles
	always @(posedge clk_i) begin
		if (hold_cnt > 0) begin
			hold_cnt <= hold_cnt - 1;
		end else if (want_i != held) begin
			hold_cnt <= GAP;
			if (want_i[0] != held[0]) begin
				held[0] <= want_i[0];
			end else if (want_i[1] != held[1]) begin
				held[1] <= want_i[1];
			end else begin
				held[2] <= want_i[2];
			end
		end
	end
	// glitch only on command, on the trigger pin only, for as long as glitch_i is high
	assign pin_o = held ^ {2'h0, glitch_i};
	assign busy_o = (hold_cnt != 0) || (want_i != held);
endmodule

// [testbench.sv]
// self-checking bench of the control input conditioner
`timescale 1ns/10ps
module testbench;
	localparam int TICK = 20;
	localparam logic [5:0] EDGE_TAB [0:15] = '{6'h20, 6'h11, 6'h04, 6'h0A, 6'h10, 6'h02,
		6'h08, 6'h01, 6'h0, 6'h0, 6'h0, 6'h0, 6'h0, 6'h0, 6'h0, 6'h0};
	localparam logic [3:0] LVL_TAB [0:3] = '{4'h8, 4'h2, 4'h4, 4'h1};
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] rv;
	logic waitreq, key_tog, beg_req, halt_req, infuse, evt_lvl, busy;
	logic [2:0] want = 3'h7;
	logic [2:0] pins;
	logic glitch = 1'b0;
	logic clr = 1'b0;
	logic [3:0] n_tog = 4'h0;
	logic [3:0] n_beg = 4'h0;
	logic [3:0] n_halt = 4'h0;
	int fail_count = 0;
	int checked = 0;

	initial begin
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	tic_conditioner #(.TICK_CYCLES(TICK)) u_tic_conditioner (.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i), .trig_pin_i(pins[0]), .dir_pin_i(pins[1]), .event_pin_i(pins[2]),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .key_toggle_o(key_tog),
		.begin_req_o(beg_req), .halt_req_o(halt_req), .infuse_o(infuse),
		.event_level_o(evt_lvl));
	tic_switch_model #(.GAP(4 * TICK)) u_tic_switch_model (.clk_i(ref_clk_i), .want_i(want),
		.glitch_i(glitch), .pin_o(pins), .busy_o(busy));

	// request pulses are counted, so a pulse longer than one cycle shows
	always @(posedge ref_clk_i) begin
		n_tog <= clr ? 4'h0 : n_tog + 4'(key_tog === 1'b1);
		n_beg <= clr ? 4'h0 : n_beg + 4'(beg_req === 1'b1);
		n_halt <= clr ? 4'h0 : n_halt + 4'(halt_req === 1'b1);
	end

	task test_done;
		$display("checks %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task timed_out(input string what);
		fail_count++;
		$display("wrong value at %0t: %s timed out", $time, what);
		test_done();
	endtask

	task check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task check_bit(input logic got, input logic exp, input string what);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk_i);
		rd <= ~w;
		wr <= w;
		addr <= a;
		wdata <= d;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		if (n >= 20) timed_out("bus");
		rv = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task drive(input logic [2:0] w);
		int n;
		@(posedge ref_clk_i);
		want <= w;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (busy !== 1'b0 && n < 500);
		if (n >= 500) timed_out("pins");
	endtask

	task clear;
		@(posedge ref_clk_i);
		clr <= 1'b1;
		@(posedge ref_clk_i);
		clr <= 1'b0;
	endtask

	function automatic logic [31:0] exp3(input logic [2:0] b);
		return {20'h0, 3'h0, b[2], 3'h0, b[1], 3'h0, b[0]};
	endfunction

	task t_reset;
		check_bit(waitreq, 1'b1, "idle wait");
		bus(1'b0, tic_pkg::TIC_CTRL_OFS, 32'h0);
		check_word(rv, 32'(tic_pkg::TIC_MODE_RST), "ctrl reset");
		bus(1'b1, tic_pkg::TIC_STATUS_OFS, 32'h0);
		bus(1'b0, tic_pkg::TIC_STATUS_OFS, 32'h0);
		check_word(rv, 32'h1F, "status idle");
		bus(1'b0, tic_pkg::TIC_EDGES_OFS, 32'h0);
		check_word(rv, 32'h0, "edges idle");
		bus(1'b0, 4'hC, 32'h0);
		check_word(rv, 32'h0, "unmapped");
	endtask

	task t_edge_modes;
		for (int i = 0; i < 16; i++) begin
			if (i < 8 || i > 11) begin
				bus(1'b1, tic_pkg::TIC_CTRL_OFS, 32'(i));
				clear();
				drive(3'h6);
				check_word(32'({n_tog, n_beg, n_halt}), exp3(EDGE_TAB[i][5:3]), "fall");
				clear();
				drive(3'h7);
				check_word(32'({n_tog, n_beg, n_halt}), exp3(EDGE_TAB[i][2:0]), "rise");
			end
		end
		bus(1'b0, tic_pkg::TIC_EDGES_OFS, 32'h0);
		check_word(rv, 32'h18, "edge count");
	endtask

	task t_level_modes;
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, tic_pkg::TIC_CTRL_OFS, 32'h8 + 32'(i));
			drive(3'h6);
			clear();
			repeat (4 * TICK) @(posedge ref_clk_i);
			check_word(32'({n_tog != 0, n_beg != 0, n_halt != 0}), {30'h0, LVL_TAB[i][3:2]}, "low");
			drive(3'h7);
			clear();
			repeat (4 * TICK) @(posedge ref_clk_i);
			check_word(32'({n_tog != 0, n_beg != 0, n_halt != 0}), {30'h0, LVL_TAB[i][1:0]}, "high");
		end
	endtask

	task t_direction;
		for (int p = 0; p < 2; p++) begin
			bus(1'b1, tic_pkg::TIC_CTRL_OFS, 32'h0C | (32'(p) << 4));
			drive(3'h5);
			check_bit(infuse, p == 0, "dir fall");
			bus(1'b0, tic_pkg::TIC_STATUS_OFS, 32'h0);
			check_word(rv & 32'hA, (p == 0) ? 32'h8 : 32'h0, "dir status");
			drive(3'h7);
			check_bit(infuse, p == 1, "dir rise");
		end
	endtask

	task t_gating;
		for (int g = 0; g < 2; g++) begin
			bus(1'b1, tic_pkg::TIC_CTRL_OFS, 32'h100 << g);
			clear();
			drive(3'h4);
			check_word(32'({n_tog, n_beg, n_halt}), 32'h0, "gated trig");
			check_bit(infuse, g == 0, "gated dir");
			bus(1'b1, tic_pkg::TIC_CTRL_OFS, 32'h0);
			drive(3'h7);
			check_bit(infuse, 1'b0, "ungated dir");
		end
	endtask

	task t_event;
		bus(1'b1, tic_pkg::TIC_CTRL_OFS, 32'h10C);
		drive(3'h3);
		check_bit(evt_lvl, 1'b0, "event low");
		bus(1'b0, tic_pkg::TIC_STATUS_OFS, 32'h0);
		check_bit(rv[2], 1'b0, "event status");
		drive(3'h7);
		check_bit(evt_lvl, 1'b1, "event high");
	endtask

	task t_glitch;
		bus(1'b1, tic_pkg::TIC_CTRL_OFS, 32'h0);
		clear();
		glitch <= 1'b1;
		repeat (5) @(posedge ref_clk_i);
		glitch <= 1'b0;
		repeat (4 * TICK) @(posedge ref_clk_i);
		check_word(32'({n_tog, n_beg, n_halt}), 32'h0, "glitch");
		bus(1'b0, tic_pkg::TIC_STATUS_OFS, 32'h0);
		check_bit(rv[0], 1'b1, "glitch level");
	endtask

	initial begin
		repeat (20) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (4 * TICK) @(posedge ref_clk_i);
		t_reset();
		t_edge_modes();
		t_level_modes();
		t_direction();
		t_gating();
		t_event();
		t_glitch();
		test_done();
	end

	initial begin
		repeat (90000) @(posedge ref_clk_i);
		timed_out("run");
	end
endmodule
